/* hw/csfm_clock_switch.sv */
// clock source switch sequencer with fail-safe monitor and axi4-lite registers
// Function
// - software may switch system clock among six sources; new select is written only while idle
// - primary submode fixed by configuration; switching never changes it
// - switching and monitor work only when the disable setting is 0
// - when disabled, new select is ignored; current shows initial setting
// - when disabled, switch request ignores writes and reads 0
// - request for current source is cleared and abandoned
// - valid switch start clears lock flag and clock fail flag
// - enable requested oscillator; crystals wait for start-up timer
// - sources using the multiplier wait for pll lock
// - count ten edges of the new clock, then switch
// - completion clears request and copies new select into current
// - old source off after switch, except kept slow rc or slow crystal
// - processor keeps running during the whole switch sequence
// - monitor enabled keeps slow internal rc running except in sleep when it is not the current source
// - failure of the current oscillator, except slow rc or in sleep, raises a trap and falls back to fast rc
// - fallback keeps the multiplier when it was in use
`include "csfm_defines.svh"
`default_nettype none
module csfm_clock_switch #(
    parameter int ADDR_W = 12,
    parameter logic [7:0] WIN_EDGES = `CSFM_WIN_EDGES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // configuration and oscillator pins
    input wire csfm_pkg::csfm_cfg_s cfg,
    input wire csfm_pkg::csfm_osc_s oscPins,
    input wire logic sleepMode,
    // clock control outputs
    output logic [2:0] sysClkSel,
    output logic [3:0] oscEnable,
    output logic pllEnable,
    output logic clockFailTrap,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic [1:0] oscOf(input logic [2:0] src);
        case (src)
            `CSFM_SRC_PRI, `CSFM_SRC_PRIPLL: oscOf = `CSFM_OSC_PRI;
            `CSFM_SRC_SLOWX: oscOf = `CSFM_OSC_SLOWX;
            `CSFM_SRC_SLOWRC: oscOf = `CSFM_OSC_SLOWRC;
            default: oscOf = `CSFM_OSC_FRC;
        endcase
    endfunction : oscOf

    function automatic logic usesPll(input logic [2:0] src);
        usesPll = (src == `CSFM_SRC_FAST_RC_WITH_MULTIPLIER) || (src == `CSFM_SRC_PRIPLL);
    endfunction : usesPll

    csfm_pkg::csfm_state_e state_ff;
    logic [2:0] curSrc_ff, newSel_ff;
    logic req_ff, lock_ff, fail_ff, keep_ff, armHigh_ff, armLow_ff;
    logic [3:0] oscEn_ff, edgeCnt_ff;
    logic pllEn_ff, trap_ff, seen_ff;
    logic [7:0] winCnt_ff;
    logic [8:0] syncA_ff, syncB_ff, syncC_ff;
    logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        syncA_ff <= oscPins;
        syncB_ff <= syncA_ff;
        syncC_ff <= syncB_ff;
    end
    wire logic [3:0] oscEdge = syncB_ff[8:5] & ~syncC_ff[8:5];
    wire logic [3:0] ostDone = syncB_ff[4:1];
    wire logic lockSync = syncB_ff[0];

    wire logic swEnable = ~cfg.switchMonitorDisableCfg;
    wire logic newEdge = oscEdge[oscOf(newSel_ff)];
    wire logic newCrystal = (oscOf(newSel_ff) == `CSFM_OSC_SLOWX) ||
        ((oscOf(newSel_ff) == `CSFM_OSC_PRI) && (cfg.primarySubmodeSelect != `CSFM_SUB_EXT));
    wire logic monActive = swEnable && !sleepMode && (oscOf(curSrc_ff) != `CSFM_OSC_SLOWRC);
    wire logic winEnd = oscEdge[`CSFM_OSC_SLOWRC] && (winCnt_ff == WIN_EDGES - 8'h01);
    wire logic failEvent = monActive && winEnd && !seen_ff && !oscEdge[oscOf(curSrc_ff)];

    // ****************************************
    // register bus
    // ****************************************
    wire logic wrFire = awready_ff && s_axi_awvalid;
    wire logic rdFire = arready_ff && s_axi_arvalid;
    wire logic wrCtrl = wrFire && (s_axi_awaddr == `CSFM_OFS_CTRL);
    wire logic wrKey = wrFire && (s_axi_awaddr == `CSFM_OFS_KEY);
    wire logic highWr = wrCtrl && s_axi_wstrb[1] && armHigh_ff && (state_ff == csfm_pkg::ST_IDLE);
    wire logic lowWr = wrCtrl && s_axi_wstrb[0] && armLow_ff;

    // accesses are served in every state so code keeps running during a switch
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            awready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `CSFM_RESP_OKAY;
        end
        else
        begin
            awready_ff <= !awready_ff && !bvalid_ff && s_axi_awvalid && s_axi_wvalid;
            if (wrFire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (wrCtrl || wrKey) ? `CSFM_RESP_OKAY : `CSFM_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= `CSFM_RESP_OKAY;
            rdata_ff <= 32'h0;
        end
        else
        begin
            arready_ff <= !arready_ff && !rvalid_ff && s_axi_arvalid;
            if (rdFire)
            begin
                rvalid_ff <= 1'b1;
                rresp_ff <= `CSFM_RESP_OKAY;
                rdata_ff <= 32'h0;
                if (s_axi_araddr == `CSFM_OFS_CTRL)
                begin
                    rdata_ff[`CSFM_CUR_LSB +: 3] <= curSrc_ff;
                    rdata_ff[`CSFM_NEW_LSB +: 3] <= newSel_ff;
                    rdata_ff[`CSFM_LOCK_BIT] <= lock_ff;
                    rdata_ff[`CSFM_FAIL_BIT] <= fail_ff;
                    rdata_ff[`CSFM_KEEP_BIT] <= keep_ff;
                    rdata_ff[`CSFM_REQ_BIT] <= req_ff;
                end
                else if (s_axi_araddr == `CSFM_OFS_KEY)
                    rdata_ff[1:0] <= {armHigh_ff, armLow_ff};
                else
                    rresp_ff <= `CSFM_RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
    end

    // a key arms one byte for the very next bus write only; any other write disarms
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            armHigh_ff <= 1'b0;
            armLow_ff <= 1'b0;
        end
        else if (wrFire)
        begin
            armHigh_ff <= wrKey && s_axi_wstrb[0] && (s_axi_wdata[7:0] == `CSFM_KEY_HIGH);
            armLow_ff <= wrKey && s_axi_wstrb[0] && (s_axi_wdata[7:0] == `CSFM_KEY_LOW);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            newSel_ff <= `CSFM_RST_NEW;
            keep_ff <= 1'b0;
        end
        else
        begin
            if (highWr)
                newSel_ff <= s_axi_wdata[`CSFM_NEW_LSB +: 3];
            if (lowWr)
                keep_ff <= s_axi_wdata[`CSFM_KEEP_BIT];
        end
    end

    // ****************************************
    // switch sequencer
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            req_ff <= 1'b0;
        else if (!swEnable)
            req_ff <= 1'b0;
        else if (failEvent || state_ff == csfm_pkg::ST_SWITCH)
            req_ff <= 1'b0;
        else if (state_ff == csfm_pkg::ST_IDLE && req_ff && newSel_ff == curSrc_ff)
            req_ff <= 1'b0;
        else if (lowWr && s_axi_wdata[`CSFM_REQ_BIT])
            req_ff <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_ff <= csfm_pkg::ST_IDLE;
            edgeCnt_ff <= 4'h0;
        end
        else if (failEvent)
            state_ff <= csfm_pkg::ST_IDLE;
        else
        begin
            case (state_ff)
                csfm_pkg::ST_IDLE:
                    if (swEnable && req_ff && newSel_ff != curSrc_ff)
                        state_ff <= csfm_pkg::ST_START;
                csfm_pkg::ST_START:
                    state_ff <= csfm_pkg::ST_WAIT_OST;
                csfm_pkg::ST_WAIT_OST:
                    if (!newCrystal || ostDone[oscOf(newSel_ff)])
                        state_ff <= csfm_pkg::ST_WAIT_LOCK;
                csfm_pkg::ST_WAIT_LOCK:
                begin
                    edgeCnt_ff <= 4'h0;
                    if (!usesPll(newSel_ff) || lockSync)
                        state_ff <= csfm_pkg::ST_COUNT;
                end
                csfm_pkg::ST_COUNT:
                    if (newEdge)
                    begin
                        edgeCnt_ff <= edgeCnt_ff + 4'h1;
                        if (edgeCnt_ff == `CSFM_SWITCH_EDGES - 4'h1)
                            state_ff <= csfm_pkg::ST_SWITCH;
                    end
                csfm_pkg::ST_SWITCH:
                    state_ff <= csfm_pkg::ST_IDLE;
                default:
                    state_ff <= csfm_pkg::ST_IDLE;
            endcase
        end
    end

    // configuration is static, so the reset branch may take the initial source
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            curSrc_ff <= cfg.initialSourceCfg;
        else if (failEvent)
            curSrc_ff <= usesPll(curSrc_ff) ? `CSFM_SRC_FAST_RC_WITH_MULTIPLIER : `CSFM_SRC_FRC;
        else if (state_ff == csfm_pkg::ST_SWITCH)
            curSrc_ff <= newSel_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            fail_ff <= 1'b0;
            lock_ff <= 1'b0;
            trap_ff <= 1'b0;
        end
        else
        begin
            trap_ff <= failEvent;
            lock_ff <= (state_ff == csfm_pkg::ST_START) ? 1'b0 : lockSync;
            if (failEvent)
                fail_ff <= 1'b1;
            else if (state_ff == csfm_pkg::ST_START || (lowWr && !s_axi_wdata[`CSFM_FAIL_BIT]))
                fail_ff <= 1'b0;
        end
    end

    // ****************************************
    // oscillator power and fail-safe window
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            oscEn_ff <= 4'h0;
            oscEn_ff[oscOf(cfg.initialSourceCfg)] <= 1'b1;
            pllEn_ff <= usesPll(cfg.initialSourceCfg);
        end
        else
        begin
            pllEn_ff <= usesPll(curSrc_ff) || (state_ff != csfm_pkg::ST_IDLE && usesPll(newSel_ff));
            if (failEvent)
                oscEn_ff[`CSFM_OSC_FRC] <= 1'b1;
            else if (state_ff == csfm_pkg::ST_START)
                oscEn_ff[oscOf(newSel_ff)] <= 1'b1;
            else if (state_ff == csfm_pkg::ST_SWITCH && oscOf(curSrc_ff) != oscOf(newSel_ff) &&
                     !(oscOf(curSrc_ff) == `CSFM_OSC_SLOWX && keep_ff))
                oscEn_ff[oscOf(curSrc_ff)] <= 1'b0;
            if (swEnable || cfg.watchdogEnable)
                oscEn_ff[`CSFM_OSC_SLOWRC] <= !sleepMode || (oscOf(curSrc_ff) == `CSFM_OSC_SLOWRC);
        end
    end

    // one missing edge window is enough; a slower current clock needs a longer window
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !monActive)
        begin
            winCnt_ff <= 8'h0;
            seen_ff <= 1'b0;
        end
        else if (winEnd)
        begin
            winCnt_ff <= 8'h0;
            seen_ff <= 1'b0;
        end
        else
        begin
            winCnt_ff <= winCnt_ff + {7'h0, oscEdge[`CSFM_OSC_SLOWRC]};
            if (oscEdge[oscOf(curSrc_ff)])
                seen_ff <= 1'b1;
        end
    end

    assign sysClkSel = curSrc_ff;
    assign oscEnable = oscEn_ff;
    assign pllEnable = pllEn_ff;
    assign clockFailTrap = trap_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = awready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_count_done;
        state_ff == csfm_pkg::ST_COUNT && newEdge && edgeCnt_ff == 4'h9 && !failEvent;
    endsequence
    sequence s_switch_step;
        state_ff == csfm_pkg::ST_SWITCH && !failEvent;
    endsequence

    a_disabled_req_low: assert property (!swEnable |=> !req_ff) else $error("request set while disabled");
    a_disabled_cur_init: assert property (!swEnable |-> curSrc_ff == cfg.initialSourceCfg)
        else $error("current source moved while disabled");
    a_redundant_abort: assert property (state_ff == csfm_pkg::ST_IDLE && req_ff && swEnable &&
        newSel_ff == curSrc_ff && !failEvent |=> !req_ff && state_ff == csfm_pkg::ST_IDLE)
        else $error("redundant switch not aborted");
    a_start_clears: assert property (state_ff == csfm_pkg::ST_START && !failEvent |=> !fail_ff && !lock_ff)
        else $error("flags not cleared at start");
    a_ost_wait: assert property (state_ff == csfm_pkg::ST_WAIT_OST && newCrystal && !ostDone[oscOf(newSel_ff)]
        |=> state_ff inside {csfm_pkg::ST_WAIT_OST, csfm_pkg::ST_IDLE}) else $error("start-up timer skipped");
    a_lock_wait: assert property (state_ff == csfm_pkg::ST_WAIT_LOCK && usesPll(newSel_ff) && !lockSync
        |=> state_ff inside {csfm_pkg::ST_WAIT_LOCK, csfm_pkg::ST_IDLE}) else $error("pll lock skipped");
    a_ten_edges: assert property ($rose(state_ff == csfm_pkg::ST_SWITCH) |-> $past(edgeCnt_ff) == 4'h9)
        else $error("switch before ten edges");
    a_switch_done: assert property (s_count_done ##1 s_switch_step |=> curSrc_ff == $past(newSel_ff) && !req_ff)
        else $error("switch completion wrong");
    a_fail_fallback: assert property (failEvent |=> clockFailTrap && fail_ff &&
        curSrc_ff == ($past(usesPll(curSrc_ff)) ? `CSFM_SRC_FAST_RC_WITH_MULTIPLIER : `CSFM_SRC_FRC))
        else $error("fail fallback wrong");
    a_slowrc_on: assert property (resetn && swEnable && !sleepMode |=> oscEnable[`CSFM_OSC_SLOWRC])
        else $error("slow rc off under monitor");
endmodule : csfm_clock_switch
`default_nettype wire

/* hw/csfm_defines.svh */
// constants for the clock switch and fail-safe monitor
`ifndef CSFM_DEFINES_SVH
`define CSFM_DEFINES_SVH
// register byte offsets
`define CSFM_OFS_CTRL 12'h000
`define CSFM_OFS_KEY 12'h004
// unlock keys written to the key register
`define CSFM_KEY_HIGH 8'h9a
`define CSFM_KEY_LOW 8'h65
// control register fields
`define CSFM_CUR_LSB 12
`define CSFM_NEW_LSB 8
`define CSFM_LOCK_BIT 5
`define CSFM_FAIL_BIT 3
`define CSFM_KEEP_BIT 1
`define CSFM_REQ_BIT 0
// source codes
`define CSFM_SRC_FRC 3'h0
`define CSFM_SRC_FAST_RC_WITH_MULTIPLIER 3'h1
`define CSFM_SRC_PRI 3'h2
`define CSFM_SRC_PRIPLL 3'h3
`define CSFM_SRC_SLOWX 3'h4
`define CSFM_SRC_SLOWRC 3'h5
// primary submode code that needs no start-up timer
`define CSFM_SUB_EXT 2'h0
// oscillator indices
`define CSFM_OSC_PRI 2'h0
`define CSFM_OSC_SLOWX 2'h1
`define CSFM_OSC_FRC 2'h2
`define CSFM_OSC_SLOWRC 2'h3
// timing and reset values
`define CSFM_SWITCH_EDGES 4'ha
`define CSFM_WIN_EDGES 8'h08
`define CSFM_RST_NEW 3'h0
`define CSFM_RESP_OKAY 2'h0
`define CSFM_RESP_SLVERR 2'h2
`endif

/* hw/csfm_pkg.sv */
// types for the clock switch and fail-safe monitor
`default_nettype none
package csfm_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_WAIT_OST, ST_WAIT_LOCK, ST_COUNT, ST_SWITCH} csfm_state_e;
    typedef struct packed {
        logic switchMonitorDisableCfg;
        logic [2:0] initialSourceCfg;
        logic [1:0] primarySubmodeSelect;
        logic watchdogEnable;
    } csfm_cfg_s;
    typedef struct packed {
        logic [3:0] clk;
        logic [3:0] startupTimer;
        logic pllLock;
    } csfm_osc_s;
endpackage : csfm_pkg
`default_nettype wire

/* tb/csfm_osc_model.sv */
// behavioural oscillator sources: gated clocks, start-up timers and pll lock
`default_nettype none
module csfm_osc_model (
    // clock
    input wire logic sys_clk,
    // oscillator control from the block
    input wire logic [3:0] oscEnable,
    input wire logic pllEnable,
    // fault injection on the primary oscillator
    input wire logic failPri,
    // oscillator pins
    output var csfm_pkg::csfm_osc_s oscPins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] clkLvl = 4'h0;
    logic [7:0] phaseCnt [4] = '{default: 8'h00};
    logic [7:0] upCnt [4] = '{default: 8'h00};
    logic [7:0] lockCnt = 8'h00;

    function automatic logic [7:0] halfPeriod(input int i);
        return (i == 3) ? 8'h06 : (i == 1) ? 8'h03 : 8'h02;
    endfunction : halfPeriod

    // ****************************************
    // clocks, start-up timers, lock
    // ****************************************
    always @(posedge sys_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            // a stopped oscillator stands low, it never holds a stale high
            if (!oscEnable[i] || (i == 0 && failPri))
            begin
                clkLvl[i] <= 1'b0;
                phaseCnt[i] <= 8'h00;
            end
            else if (phaseCnt[i] == halfPeriod(i) - 8'h01)
            begin
                clkLvl[i] <= ~clkLvl[i];
                phaseCnt[i] <= 8'h00;
            end
            else
                phaseCnt[i] <= phaseCnt[i] + 8'h01;
            upCnt[i] <= !oscEnable[i] ? 8'h00 : (upCnt[i] < 8'h14) ? upCnt[i] + 8'h01 : upCnt[i];
        end
        lockCnt <= !pllEnable ? 8'h00 : (lockCnt < 8'h10) ? lockCnt + 8'h01 : lockCnt;
    end

    always_comb
    begin
        oscPins.clk = clkLvl;
        for (int i = 0; i < 4; i++)
            oscPins.startupTimer[i] = (upCnt[i] >= 8'h14);
        oscPins.pllLock = (lockCnt >= 8'h10);
    end
endmodule : csfm_osc_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the clock switch over its register bus
`include "csfm_defines.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    csfm_pkg::csfm_cfg_s cfg = 7'b0_000_01_0;
    csfm_pkg::csfm_osc_s oscPins;
    logic sleepMode = 1'b0, failPri = 1'b0, keepOn = 1'b0;
    logic [2:0] sysClkSel;
    logic [3:0] oscEnable;
    logic pllEnable, clockFailTrap;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int failCount = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    csfm_clock_switch #(.ADDR_W(12), .WIN_EDGES(8'h02)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .oscPins(oscPins), .sleepMode(sleepMode),
        .sysClkSel(sysClkSel), .oscEnable(oscEnable), .pllEnable(pllEnable), .clockFailTrap(clockFailTrap),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    csfm_osc_model u_osc (
        .sys_clk(sys_clk), .oscEnable(oscEnable), .pllEnable(pllEnable), .failPri(failPri), .oscPins(oscPins)
    );

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone))
        begin
            @(posedge sys_clk);
            if (!awDone && s_axi_awready === 1'b1)
            begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1)
            begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge sys_clk);
        resp = s_axi_bresp;
    endtask : axiWrite

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge sys_clk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge sys_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axiRead

    task automatic doReset();
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : doReset

    // unlock each byte, request, then poll until the request bit drops
    task automatic doSwitch(input logic [2:0] src);
        int n;
        n = 0;
        axiWrite(`CSFM_OFS_KEY, {24'h0, `CSFM_KEY_HIGH}, 4'h1);
        axiWrite(`CSFM_OFS_CTRL, {21'h0, src, 8'h00}, 4'h2);
        axiWrite(`CSFM_OFS_KEY, {24'h0, `CSFM_KEY_LOW}, 4'h1);
        // fail flag written as 1 so only the start of a switch can clear it
        axiWrite(`CSFM_OFS_CTRL, {28'h0, 1'b1, 1'b0, keepOn, 1'b1}, 4'h1);
        axiRead(`CSFM_OFS_CTRL, rd, resp);
        while (rd[0] === 1'b1 && n < 100)
        begin
            axiRead(`CSFM_OFS_CTRL, rd, resp);
            n++;
        end
        check("request bit", 32'(rd[0]), 32'h0);
    endtask : doSwitch

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        int n;
        doReset();
        axiRead(`CSFM_OFS_CTRL, rd, resp);
        check("current after reset", 32'(rd[14:12]), 32'h0);
        check("slow rc on", 32'(oscEnable[3]), 32'h1);
        doSwitch(3'h0);
        check("redundant current", 32'(rd[14:12]), 32'h0);
        doSwitch(3'h2);
        check("sel primary", 32'(sysClkSel), 32'h2);
        check("current primary", 32'(rd[14:12]), 32'h2);
        check("fast rc off", 32'(oscEnable[2]), 32'h0);
        check("primary on", 32'(oscEnable[0]), 32'h1);
        axiWrite(`CSFM_OFS_CTRL, {21'h0, 3'h4, 8'h00}, 4'h2);
        axiRead(`CSFM_OFS_CTRL, rd, resp);
        check("unkeyed write", 32'(rd[10:8]), 32'h2);
        axiWrite(`CSFM_OFS_KEY, {24'h0, `CSFM_KEY_HIGH}, 4'h1);
        axiRead(`CSFM_OFS_KEY, rd, resp);
        check("high armed", rd, 32'h2);
        axiWrite(12'h010, 32'h0, 4'hf);
        check("unmapped bresp", 32'(resp), 32'(`CSFM_RESP_SLVERR));
        axiRead(`CSFM_OFS_KEY, rd, resp);
        check("key disarmed", rd, 32'h0);
        doSwitch(3'h3);
        check("sel primary pll", 32'(sysClkSel), 32'h3);
        check("lock bit", 32'(rd[5]), 32'h1);
        check("pll on", 32'(pllEnable), 32'h1);
        failPri <= 1'b1;
        n = 0;
        while (clockFailTrap !== 1'b1 && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        check("fail trap", 32'(clockFailTrap), 32'h1);
        repeat (3) @(posedge sys_clk);
        check("trap pulse", 32'(clockFailTrap), 32'h0);
        check("fallback sel", 32'(sysClkSel), 32'h1);
        axiRead(`CSFM_OFS_CTRL, rd, resp);
        check("fail flag", 32'(rd[3]), 32'h1);
        failPri <= 1'b0;
        // plain fast rc after the fast rc with multiplier fallback, so the pll turns off
        doSwitch(3'h0);
        check("fail flag cleared", 32'(rd[3]), 32'h0);
        check("pll off", 32'(pllEnable), 32'h0);
        keepOn <= 1'b1;
        doSwitch(3'h4);
        check("sel slow crystal", 32'(sysClkSel), 32'h4);
        doSwitch(3'h0);
        check("slow crystal kept", 32'(oscEnable[1]), 32'h1);
        sleepMode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("slow rc sleep", 32'(oscEnable[3]), 32'h0);
        sleepMode <= 1'b0;
        axiRead(12'h010, rd, resp);
        check("unmapped resp", 32'(resp), 32'(`CSFM_RESP_SLVERR));
        check("unmapped data", rd, 32'h0);
        cfg <= 7'b1_101_01_0;
        doReset();
        axiRead(`CSFM_OFS_CTRL, rd, resp);
        check("disabled current", 32'(rd[14:12]), 32'h5);
        axiWrite(`CSFM_OFS_KEY, {24'h0, `CSFM_KEY_LOW}, 4'h1);
        axiWrite(`CSFM_OFS_CTRL, 32'h1, 4'h1);
        axiRead(`CSFM_OFS_CTRL, rd, resp);
        check("disabled request", 32'(rd[0]), 32'h0);
        doSwitch(3'h2);
        check("disabled sel", 32'(sysClkSel), 32'h5);
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failCount++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
